// file: logic/cpu_mode_access_guard.sv
// mode-based guard for cpu memory and special function register accesses
// assumes cpu requests on mclk, sfr bank answers bank_rdata in the cycle of bank_rd
//
// Our own choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "guard_regs.svh"

module cpu_mode_access_guard (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // mode source
    input  wire logic [7:0]  status_word_upper,
    input  wire logic [1:0]  mode_state,
    // segment entry in use
    input  wire logic [2:0]  seg_mem_rights,
    input  wire logic [15:0] seg_hw_rights,
    // memory request
    input  wire logic        mem_req,
    input  wire logic        copro_req,
    input  wire logic [1:0]  mem_space,
    input  wire logic [15:0] mem_addr,
    input  wire logic        mem_rd,
    input  wire logic        mem_wr,
    input  wire logic        mem_exec,
    output logic             mem_grant,
    output logic             mem_deny,
    // sfr request from cpu
    input  wire logic        sfr_req,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_rd,
    input  wire logic        sfr_wr,
    input  wire logic [7:0]  sfr_wdata,
    output logic [7:0]       sfr_rdata,
    output logic             sfr_done,
    output logic             sfr_denied,
    // sfr bank
    output logic             bank_rd,
    output logic             bank_wr,
    output logic [7:0]       bank_addr,
    output logic [7:0]       bank_wdata,
    input  wire logic [7:0]  bank_rdata
);
    guard_pkg::cpu_mode_t  mode;
    guard_pkg::mem_space_t space;
    guard_pkg::sfr_group_t group;

    logic [7:0]  fw_ctrl_low;
    logic [7:0]  fw_ctrl_high;
    logic [7:0]  exch_base_low;
    logic [7:0]  exch_base_high;
    logic [7:0]  exch_size_low;
    logic [7:0]  exch_size_high;
    logic [15:0] seg_table_ptr;
    logic [15:0] mem_deny_count;
    logic [15:0] sfr_deny_count;

    logic        ahb_wr_pend;
    logic [7:0]  ahb_wr_addr;
    logic [31:0] next_hrdata;
    logic        ahb_take;

    logic        hit_test_rom;
    logic        hit_acm;
    logic        hit_os_ee;
    logic        hit_sec_row;
    logic        hit_os_ram;
    logic        hit_exch;
    logic        seg_ok;
    logic        seg_enabled;
    logic        next_mem_grant;

    logic        next_sfr_rd_ok;
    logic        next_sfr_wr_ok;
    logic [3:0]  hw_comp;
    logic [15:0] fw_rights;
    logic        read_pend;
    logic        read_hit;

    // mode in force for this cycle's requests
    always_comb begin
        unique case (mode_state)
            `MODE_STATE_BOOT: mode = guard_pkg::mode_boot;
            `MODE_STATE_TEST: mode = guard_pkg::mode_test;
            `MODE_STATE_CL:   mode = guard_pkg::mode_contactless;
            default: begin
                mode = status_word_upper[`PSW_SYSTEM_BIT] ? guard_pkg::mode_system : guard_pkg::mode_user;
            end
        endcase
    end

    // ahb-lite slave: zero wait states, always okay
    assign ahb_take = hsel && hready && htrans[`AHB_HTRANS_NONSEQ_BIT];

    always_comb begin
        next_hrdata = 32'h00000000;
        unique case (haddr[`GREG_DECODE_MSB:0])
            `GREG_FW_CTRL_LOW:    next_hrdata = {24'h000000, fw_ctrl_low};
            `GREG_FW_CTRL_HIGH:   next_hrdata = {24'h000000, fw_ctrl_high};
            `GREG_EXCH_BASE_LOW:  next_hrdata = {24'h000000, exch_base_low};
            `GREG_EXCH_BASE_HIGH: next_hrdata = {24'h000000, exch_base_high};
            `GREG_EXCH_SIZE_LOW:  next_hrdata = {24'h000000, exch_size_low};
            `GREG_EXCH_SIZE_HIGH: next_hrdata = {24'h000000, exch_size_high};
            `GREG_SEG_TABLE_PTR:  next_hrdata = {16'h0000, seg_table_ptr};
            `GREG_DENY_COUNT:     next_hrdata = {sfr_deny_count, mem_deny_count};
            default:              next_hrdata = 32'h00000000;
        endcase
        if (haddr[31:8] != 24'h000000) begin
            next_hrdata = 32'h00000000;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            hreadyout   <= 1'b1;
            hresp       <= `AHB_HRESP_OKAY;
            hrdata      <= 32'h00000000;
            ahb_wr_pend <= 1'b0;
            ahb_wr_addr <= 8'h00;
        end else begin
            hreadyout   <= 1'b1;
            hresp       <= `AHB_HRESP_OKAY;
            ahb_wr_pend <= ahb_take && hwrite && (haddr[31:8] == 24'h000000);
            ahb_wr_addr <= haddr[7:0];
            if (ahb_take && !hwrite) begin
                hrdata <= next_hrdata;
            end
        end
    end

    // configuration registers; segment pointer zero keeps every segment off
    always_ff @(posedge mclk) begin
        if (rst) begin
            fw_ctrl_low    <= `GRST_BYTE;
            fw_ctrl_high   <= `GRST_BYTE;
            exch_base_low  <= `GRST_BYTE;
            exch_base_high <= `GRST_BYTE;
            exch_size_low  <= `GRST_BYTE;
            exch_size_high <= `GRST_BYTE;
            seg_table_ptr  <= `GRST_SEG_PTR;
        end else if (ahb_wr_pend) begin
            unique case (ahb_wr_addr)
                `GREG_FW_CTRL_LOW:    fw_ctrl_low    <= hwdata[7:0];
                `GREG_FW_CTRL_HIGH:   fw_ctrl_high   <= hwdata[7:0];
                `GREG_EXCH_BASE_LOW:  exch_base_low  <= hwdata[7:0];
                `GREG_EXCH_BASE_HIGH: exch_base_high <= hwdata[7:0];
                `GREG_EXCH_SIZE_LOW:  exch_size_low  <= hwdata[7:0];
                `GREG_EXCH_SIZE_HIGH: exch_size_high <= hwdata[7:0];
                `GREG_SEG_TABLE_PTR:  seg_table_ptr  <= hwdata[15:0];
                default: begin
                end
            endcase
        end
    end

    // memory partition windows
    addr_window #(.AW(16)) u_test_rom (
        .addr (mem_addr),
        .base (`TEST_ROM_BASE),
        .size (`TEST_ROM_SIZE),
        .hit  (hit_test_rom)
    );
    addr_window #(.AW(16)) u_acm (
        .addr (mem_addr),
        .base (`ACM_BASE),
        .size (`ACM_SIZE),
        .hit  (hit_acm)
    );
    addr_window #(.AW(16)) u_os_ee (
        .addr (mem_addr),
        .base (`OS_EE_BASE),
        .size (`OS_EE_SIZE),
        .hit  (hit_os_ee)
    );
    addr_window #(.AW(16)) u_sec_row (
        .addr (mem_addr),
        .base (`SEC_ROW_BASE),
        .size (`SEC_ROW_SIZE),
        .hit  (hit_sec_row)
    );
    addr_window #(.AW(16)) u_os_ram (
        .addr (mem_addr),
        .base (`OS_RAM_BASE),
        .size (`OS_RAM_SIZE),
        .hit  (hit_os_ram)
    );
    addr_window #(.AW(16)) u_exch (
        .addr (mem_addr),
        .base ({exch_base_high, exch_base_low}),
        .size ({exch_size_high, exch_size_low}),
        .hit  (hit_exch)
    );

    // a segment with no rights, or no table at all, is treated as off
    assign seg_enabled = (seg_table_ptr != 16'h0000) && (seg_mem_rights != 3'b000);
    assign seg_ok      = seg_enabled && (!mem_rd || seg_mem_rights[0])
                         && (!mem_wr || seg_mem_rights[1]) && (!mem_exec || seg_mem_rights[2]);
    assign space       = guard_pkg::mem_space_t'(mem_space);

    always_comb begin
        next_mem_grant = 1'b0;
        if (copro_req) begin
            // coprocessor bypasses cpu mode: eeprom read, own ram read and write
            unique case (space)
                guard_pkg::space_eeprom:  next_mem_grant = !mem_wr && !mem_exec;
                guard_pkg::space_pkc_ram: next_mem_grant = !mem_exec;
                default:                  next_mem_grant = 1'b0;
            endcase
        end else begin
            unique case (space)
                guard_pkg::space_rom: begin
                    unique case (mode)
                        guard_pkg::mode_boot:        next_mem_grant = hit_test_rom && !mem_wr;
                        guard_pkg::mode_contactless: next_mem_grant = (hit_test_rom && !mem_wr)
                                                                      || (hit_acm && !mem_wr && !mem_exec);
                        guard_pkg::mode_test:        next_mem_grant = !mem_wr;
                        guard_pkg::mode_system:      next_mem_grant = !hit_test_rom && !mem_wr;
                        guard_pkg::mode_user:        next_mem_grant = !hit_test_rom && !mem_wr && seg_ok;
                    endcase
                end
                guard_pkg::space_eeprom: begin
                    unique case (mode)
                        guard_pkg::mode_boot,
                        guard_pkg::mode_contactless: next_mem_grant = hit_os_ee
                                                                      || (hit_sec_row && !mem_wr && !mem_exec);
                        guard_pkg::mode_test:        next_mem_grant = 1'b1;
                        guard_pkg::mode_system:      next_mem_grant = !hit_os_ee;
                        guard_pkg::mode_user:        next_mem_grant = !hit_os_ee && seg_ok;
                    endcase
                end
                guard_pkg::space_ram: begin
                    unique case (mode)
                        guard_pkg::mode_boot:        next_mem_grant = hit_os_ram && !mem_exec;
                        guard_pkg::mode_contactless: next_mem_grant = (hit_os_ram || (!hit_os_ram && hit_exch))
                                                                      && !mem_exec;
                        guard_pkg::mode_test:        next_mem_grant = !mem_exec;
                        guard_pkg::mode_system:      next_mem_grant = !hit_os_ram && !mem_exec;
                        guard_pkg::mode_user:        next_mem_grant = !hit_os_ram && !mem_exec && seg_ok;
                    endcase
                end
                default: next_mem_grant = 1'b0;
            endcase
        end
        // a request naming no operation grants nothing
        if (!(mem_rd || mem_wr || mem_exec)) begin
            next_mem_grant = 1'b0;
        end
    end

    // verdict before the memory is touched
    always_ff @(posedge mclk) begin
        if (rst) begin
            mem_grant <= 1'b0;
            mem_deny  <= 1'b0;
        end else begin
            mem_grant <= mem_req && next_mem_grant;
            mem_deny  <= mem_req && !next_mem_grant;
        end
    end

    // sfr group decode
    always_comb begin
        if (sfr_addr <= `SFR_CPU_HI && sfr_addr >= `SFR_CPU_LO) begin
            group = guard_pkg::grp_cpu;
        end else if (sfr_addr >= `SFR_SEG_LO && sfr_addr <= `SFR_SEG_HI) begin
            group = guard_pkg::grp_segcfg;
        end else if (sfr_addr >= `SFR_SYS_LO && sfr_addr <= `SFR_SYS_HI) begin
            group = guard_pkg::grp_sysmgmt;
        end else if (sfr_addr >= `SFR_FW_LO && sfr_addr <= `SFR_FW_HI) begin
            group = guard_pkg::grp_fwcfg;
        end else if (sfr_addr >= `SFR_OS_LO && sfr_addr <= `SFR_OS_HI) begin
            group = guard_pkg::grp_osreg;
        end else if (sfr_addr >= `SFR_HW_LO) begin
            group = guard_pkg::grp_hw;
        end else begin
            // below the cpu block and the test range both stay boot- and test-mode only
            group = guard_pkg::grp_test;
        end
    end

    assign hw_comp = sfr_addr[`SFR_HW_COMP_MSB:`SFR_HW_COMP_LSB];
    // one firewall bit per hardware component
    assign fw_rights = {fw_ctrl_high, fw_ctrl_low};

    always_comb begin
        next_sfr_rd_ok = 1'b0;
        next_sfr_wr_ok = 1'b0;
        if (mode == guard_pkg::mode_boot || mode == guard_pkg::mode_test) begin
            next_sfr_rd_ok = 1'b1;
            next_sfr_wr_ok = 1'b1;
        end else begin
            unique case (group)
                guard_pkg::grp_cpu: begin
                    next_sfr_rd_ok = 1'b1;
                    next_sfr_wr_ok = 1'b1;
                end
                guard_pkg::grp_segcfg: begin
                    next_sfr_rd_ok = (mode == guard_pkg::mode_system);
                    next_sfr_wr_ok = (mode == guard_pkg::mode_system);
                end
                guard_pkg::grp_sysmgmt: begin
                    next_sfr_rd_ok = (mode == guard_pkg::mode_system)
                                     || (sfr_addr == `SFR_STATUS_UPPER);
                    next_sfr_wr_ok = (mode == guard_pkg::mode_system);
                end
                guard_pkg::grp_fwcfg: begin
                    next_sfr_rd_ok = (mode == guard_pkg::mode_system) || (mode == guard_pkg::mode_contactless);
                    next_sfr_wr_ok = (mode == guard_pkg::mode_system);
                end
                guard_pkg::grp_osreg: begin
                    next_sfr_rd_ok = (mode == guard_pkg::mode_contactless);
                    next_sfr_wr_ok = (mode == guard_pkg::mode_contactless);
                end
                guard_pkg::grp_hw: begin
                    unique case (mode)
                        guard_pkg::mode_system: begin
                            next_sfr_rd_ok = 1'b1;
                            next_sfr_wr_ok = 1'b1;
                        end
                        guard_pkg::mode_contactless: begin
                            next_sfr_rd_ok = fw_rights[hw_comp]
                                             || (sfr_addr == `SFR_CLOCK_SELECT);
                            next_sfr_wr_ok = fw_rights[hw_comp];
                        end
                        guard_pkg::mode_user: begin
                            next_sfr_rd_ok = (seg_table_ptr != 16'h0000) && seg_hw_rights[hw_comp];
                            next_sfr_wr_ok = (seg_table_ptr != 16'h0000) && seg_hw_rights[hw_comp];
                        end
                        default: begin
                        end
                    endcase
                end
                default: begin
                end
            endcase
        end
        // fixed restrictions hold in every mode
        if (sfr_addr == `SFR_HIDDEN_0 || sfr_addr == `SFR_HIDDEN_1 || sfr_addr == `SFR_HIDDEN_2
            || sfr_addr == `SFR_KEY_A || sfr_addr == `SFR_KEY_D) begin
            next_sfr_rd_ok = 1'b0;
        end
        // segmentation config stays closed even to boot and test code
        if (group == guard_pkg::grp_segcfg && mode != guard_pkg::mode_system) begin
            next_sfr_rd_ok = 1'b0;
            next_sfr_wr_ok = 1'b0;
        end
        if (sfr_addr == `SFR_RANDOM_VALUE) begin
            next_sfr_wr_ok = 1'b0;
        end
    end

    // stage 1: forward only granted operations, so denied reads cause no side effect
    always_ff @(posedge mclk) begin
        if (rst) begin
            bank_rd    <= 1'b0;
            bank_wr    <= 1'b0;
            bank_addr  <= 8'h00;
            bank_wdata <= 8'h00;
            read_pend  <= 1'b0;
            read_hit   <= 1'b0;
        end else begin
            bank_rd    <= sfr_req && sfr_rd && next_sfr_rd_ok;
            bank_wr    <= sfr_req && sfr_wr && next_sfr_wr_ok;
            bank_addr  <= sfr_addr;
            bank_wdata <= sfr_wdata;
            read_pend  <= sfr_req;
            read_hit   <= sfr_req && (sfr_rd ? next_sfr_rd_ok : 1'b1) && (sfr_wr ? next_sfr_wr_ok : 1'b1);
        end
    end

    // stage 2: answer; a denied read gives zero
    always_ff @(posedge mclk) begin
        if (rst) begin
            sfr_rdata  <= 8'h00;
            sfr_done   <= 1'b0;
            sfr_denied <= 1'b0;
        end else begin
            sfr_rdata  <= bank_rd ? bank_rdata : 8'h00;
            sfr_done   <= read_pend;
            sfr_denied <= read_pend && !read_hit;
        end
    end

    // saturating denial counters, visible to software
    always_ff @(posedge mclk) begin
        if (rst) begin
            mem_deny_count <= `GRST_COUNT;
            sfr_deny_count <= `GRST_COUNT;
        end else begin
            if (mem_deny && mem_deny_count != 16'hffff) begin
                mem_deny_count <= mem_deny_count + 16'h0001;
            end
            if (read_pend && !read_hit && sfr_deny_count != 16'hffff) begin
                sfr_deny_count <= sfr_deny_count + 16'h0001;
            end
        end
    end
endmodule // cpu_mode_access_guard

// file: shared/guard_regs.svh
// offsets, field positions, reset values and address maps of the access guard
// assumes byte addresses on a 32-bit AHB-Lite bus; cpu memory spaces are 16-bit each
`ifndef GUARD_REGS_SVH
`define GUARD_REGS_SVH

// ahb register byte offsets
`define GREG_FW_CTRL_LOW      8'h00
`define GREG_FW_CTRL_HIGH     8'h04
`define GREG_EXCH_BASE_LOW    8'h08
`define GREG_EXCH_BASE_HIGH   8'h0c
`define GREG_EXCH_SIZE_LOW    8'h10
`define GREG_EXCH_SIZE_HIGH   8'h14
`define GREG_SEG_TABLE_PTR    8'h18
`define GREG_DENY_COUNT       8'h1c
`define GREG_DECODE_MSB       7

// reset values
`define GRST_BYTE             8'h00
`define GRST_SEG_PTR          16'h0000
`define GRST_COUNT            16'h0000

// ahb encodings
`define AHB_HTRANS_NONSEQ_BIT 1
`define AHB_HRESP_OKAY        1'b0

// mode selection
`define MODE_STATE_PSW        2'b00
`define MODE_STATE_BOOT       2'b01
`define MODE_STATE_TEST       2'b10
`define MODE_STATE_CL         2'b11
`define PSW_SYSTEM_BIT        7

// memory partitions
`define TEST_ROM_BASE         16'h0000
`define TEST_ROM_SIZE         16'h2000
`define ACM_BASE              16'h2000
`define ACM_SIZE              16'h0040
`define OS_EE_BASE            16'h0000
`define OS_EE_SIZE            16'h1000
`define SEC_ROW_BASE          16'h1000
`define SEC_ROW_SIZE          16'h0020
`define OS_RAM_BASE           16'h0000
`define OS_RAM_SIZE           16'h0400

// special function register group ranges (inclusive bounds)
`define SFR_CPU_LO            8'h80
`define SFR_CPU_HI            8'h8f
`define SFR_SEG_LO            8'h90
`define SFR_SEG_HI            8'h97
`define SFR_SYS_LO            8'h98
`define SFR_SYS_HI            8'h9f
`define SFR_FW_LO             8'ha0
`define SFR_FW_HI             8'ha7
`define SFR_OS_LO             8'ha8
`define SFR_OS_HI             8'haf
`define SFR_TEST_LO           8'hb0
`define SFR_TEST_HI           8'hbf
`define SFR_HW_LO             8'hc0

// individual registers
`define SFR_STATUS_UPPER      8'h98
`define SFR_HIDDEN_0          8'h9d
`define SFR_HIDDEN_1          8'h9e
`define SFR_HIDDEN_2          8'h9f
`define SFR_CLOCK_SELECT      8'hc0
`define SFR_RANDOM_VALUE      8'hc4
`define SFR_KEY_A             8'hc8
`define SFR_KEY_D             8'hc9
`define SFR_HW_COMP_LSB       2
`define SFR_HW_COMP_MSB       5

`endif

// file: shared/guard_pkg.sv
// types shared by the access guard files
// assumes the constants of guard_regs.svh
package guard_pkg;
    typedef enum logic [2:0] {
        mode_boot,
        mode_test,
        mode_contactless,
        mode_system,
        mode_user
    } cpu_mode_t;

    typedef enum logic [1:0] {
        space_rom,
        space_eeprom,
        space_ram,
        space_pkc_ram
    } mem_space_t;

    typedef enum logic [2:0] {
        grp_cpu,
        grp_segcfg,
        grp_sysmgmt,
        grp_fwcfg,
        grp_osreg,
        grp_test,
        grp_hw
    } sfr_group_t;
endpackage

// file: logic/addr_window.sv
// address window compare: base inclusive, base plus size exclusive
// assumes base plus size does not need to wrap; carry is kept so it cannot alias
`timescale 1ns/1ps
module addr_window #(
    parameter int AW = 16
) (
    // compare
    input  wire logic [AW-1:0] addr,
    input  wire logic [AW-1:0] base,
    input  wire logic [AW-1:0] size,
    output logic               hit
);
    logic [AW:0] limit;

    assign limit = {1'b0, base} + {1'b0, size};
    assign hit   = ({1'b0, addr} >= {1'b0, base}) && ({1'b0, addr} < limit);
endmodule // addr_window

// file: tb/cpu_mode_access_guard_asserts.sv
// port checker for the access guard
// assumes bind onto the guard, one mclk domain
`timescale 1ns/1ps
module cpu_mode_access_guard_asserts (
    // clock, reset, mode
    input wire logic       mclk, rst,
    input wire logic [1:0] mode_state, mem_space,
    input wire logic [7:0] status_word_upper, sfr_addr, sfr_rdata,
    // requests and answers
    input wire logic       mem_req, copro_req, mem_exec, mem_grant, mem_deny,
    input wire logic       sfr_req, sfr_rd, sfr_wr, sfr_done, bank_rd, bank_wr
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    wire sys = mode_state == 2'h0 && status_word_upper[7];
    sequence s_idle; ##1 !bank_rd && !bank_wr; endsequence
    sequence s_ans; ##1 1'b1 ##1 sfr_done; endsequence
    property p_done; sfr_req |-> s_ans; endproperty
    a_done: assert property (p_done) else $error("no done");
    property p_zero; sfr_done && !$past(bank_rd) |-> sfr_rdata == 8'h00; endproperty
    a_zero: assert property (p_zero) else $error("data leak");
    property p_hide; sfr_req && sfr_rd && sfr_addr inside {[8'h9d:8'h9f], 8'hc8, 8'hc9} |-> ##1 !bank_rd; endproperty
    a_hide: assert property (p_hide) else $error("hidden read");
    property p_rnd; sfr_req && sfr_wr && sfr_addr == 8'hc4 |-> ##1 !bank_wr; endproperty
    a_rnd: assert property (p_rnd) else $error("random written");
    property p_seg; sfr_req && sfr_addr inside {[8'h90:8'h97]} && !sys |-> s_idle; endproperty
    a_seg: assert property (p_seg) else $error("seg cfg reached");
    property p_cpu; sfr_req && sfr_rd && sfr_addr inside {[8'h80:8'h8f]} |-> ##1 bank_rd; endproperty
    a_cpu: assert property (p_cpu) else $error("cpu reg refused");
    property p_mem; mem_req |=> mem_grant ^ mem_deny; endproperty
    a_mem: assert property (p_mem) else $error("no verdict");
    property p_ram; mem_req && !copro_req && mem_exec && mem_space == 2'h2 |=> mem_deny; endproperty
    a_ram: assert property (p_ram) else $error("ram exec");
endmodule // cpu_mode_access_guard_asserts
bind cpu_mode_access_guard cpu_mode_access_guard_asserts cpu_mode_access_guard_asserts_inst (.*);

// file: tb/sfr_bank_model.sv
// sfr bank stand-in answering reads in the strobe cycle
// assumes registered bank strobes on mclk
`timescale 1ns/1ps
module sfr_bank_model (
    // strobes
    input  wire logic       mclk, bank_rd, bank_wr,
    input  wire logic [7:0] bank_addr, bank_wdata,
    // read data
    output logic      [7:0] bank_rdata
);
    logic [7:0] mem [256];
    logic [7:0] junk = 8'h00;
    initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hc3;
    // moving pattern when idle, so a stale byte never passes
    assign bank_rdata = bank_rd ? mem[bank_addr] : junk;
    always @(posedge mclk) begin
        junk <= junk + 8'h35;
        if (bank_wr) mem[bank_addr] <= bank_wdata;
    end
endmodule // sfr_bank_model

// file: tb/tb_cpu_mode_access_guard.sv
// self-checking bench for the access guard
// assumes the bank model on the sfr far side
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; $display("MISMATCH %0t %h %h", $time, a, b); end end
module tb_cpu_mode_access_guard;
    logic mclk = 0, rst = 1, hsel = 0, hwrite = 0, mem_req = 0, copro_req = 0, mem_rd = 0, mem_wr = 0, mem_exec = 0;
    logic sfr_req = 0, sfr_rd = 0, sfr_wr = 0, hreadyout, hresp, mem_grant, mem_deny, sfr_done, sfr_denied, bank_rd, bank_wr;
    logic [1:0]  htrans = 0, mode_state = 0, mem_space = 0;
    logic [2:0]  hsize = 3'h2, seg_mem_rights = 3'h7;
    logic [7:0]  status_word_upper = 0, sfr_addr = 0, sfr_wdata = 0, sfr_rdata, bank_addr, bank_wdata, bank_rdata;
    logic [15:0] seg_hw_rights = 0, mem_addr = 0, fw = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
    logic [7:0]  sh [256];
    wire         hready = hreadyout;
    int n_fail = 0, compares = 0, nd = 0;
    cpu_mode_access_guard cpu_mode_access_guard_inst (.*);
    sfr_bank_model sfr_bank_model_inst (.*);
    initial forever #4 mclk = ~mclk;
    function automatic bit ok(int m, int a, bit w);
        int c = (a >> 2) & 15;
        if (a inside {[128:143]}) return 1;
        if (!w && a inside {[157:159], 200, 201}) return 0;
        if (w && a == 196) return 0;
        if (a inside {[144:151]}) return m == 3;
        if (m < 2) return 1;
        if (a == 152 && !w) return 1;
        if (a inside {[152:159]}) return m == 3;
        if (a inside {[160:167]}) return m == 3 || (m == 2 && !w);
        if (a inside {[168:175]}) return m == 2;
        if (a < 192 || m == 3) return a >= 192;
        if (m == 2) return fw[c] || (a == 192 && !w);
        return seg_hw_rights[c];
    endfunction
    task automatic ahb(input bit w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        hsel <= 1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 0; hsel <= 0; hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic sfr(input bit w, input logic [7:0] a, d);
        int m;
        bit g;
        @(posedge mclk);
        m = mode_state == 1 ? 0 : mode_state == 2 ? 1 : mode_state == 3 ? 2 : status_word_upper[7] ? 3 : 4;
        g = ok(m, a, w);
        sfr_req <= 1; sfr_rd <= !w; sfr_wr <= w; sfr_addr <= a; sfr_wdata <= d;
        @(posedge mclk) sfr_req <= 0;
        @(posedge mclk) #1;
        `CHK(sfr_done, 1'b1)
        `CHK(sfr_denied, !g)
        if (!g) nd++;
        if (!w) `CHK(sfr_rdata, g ? sh[a] : 8'h00)
        if (w && g) sh[a] = d;
    endtask
    task automatic mr(input logic [1:0] ms, sp, input logic [7:0] psw, input logic [15:0] a, input logic [2:0] op, e);
        @(posedge mclk);
        mode_state <= ms; status_word_upper <= psw; mem_space <= sp; mem_addr <= a;
        {mem_exec, mem_wr, mem_rd} <= op; mem_req <= 1;
        @(posedge mclk) mem_req <= 0;
        #1 `CHK(mem_grant, e[0])
        `CHK(mem_deny, !e[0])
    endtask
    task automatic wrap_up;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #200000 n_fail++;
        wrap_up;
    end
    initial begin
        for (int i = 0; i < 256; i++) sh[i] = 8'(i) ^ 8'hc3;
        void'($urandom(31556));
        repeat (3) @(posedge mclk);
        rst <= 0;
        mr(0, 1, 8'h00, 16'h4000, 3'h1, 0);
        ahb(0, 8'h18, 0); `CHK(r, 32'h0)
        ahb(1, 8'h18, 32'h100);
        ahb(0, 8'h40, 0); `CHK(r, 32'h0)
        fw = 16'($urandom);
        ahb(1, 8'h00, {24'h0, fw[7:0]}); ahb(1, 8'h04, {24'h0, fw[15:8]});
        ahb(0, 8'h04, 0); `CHK(r, {24'h0, fw[15:8]})
        ahb(1, 8'h0c, 32'h8); ahb(1, 8'h14, 32'h1);
        mr(3, 2, 8'h00, 16'h0810, 3'h3, 1);
        mr(3, 2, 8'h00, 16'h0910, 3'h1, 0);
        mr(1, 0, 8'h00, 16'h0100, 3'h5, 1);
        mr(1, 0, 8'h00, 16'h0100, 3'h2, 0);
        mr(2, 0, 8'h00, 16'hc000, 3'h1, 1);
        mr(2, 2, 8'h00, 16'h0200, 3'h4, 0);
        mr(0, 1, 8'h80, 16'h4000, 3'h7, 1);
        mr(0, 0, 8'h80, 16'h0100, 3'h1, 0);
        mr(3, 0, 8'h00, 16'h2010, 3'h1, 1);
        mr(3, 1, 8'h00, 16'h1000, 3'h1, 1);
        mr(0, 1, 8'h00, 16'h4000, 3'h1, 1);
        seg_mem_rights <= 0;
        mr(0, 1, 8'h00, 16'h4000, 3'h1, 0);
        copro_req <= 1;
        mr(0, 1, 8'h00, 16'h4000, 3'h1, 1);
        copro_req <= 0;
        repeat (1000) begin
            @(posedge mclk);
            mode_state <= 2'($urandom); status_word_upper <= 8'($urandom); seg_hw_rights <= 16'($urandom);
            sfr(1'($urandom), 8'($urandom % 160 + 96), 8'($urandom));
        end
        ahb(0, 8'h1c, 0); `CHK(r, {16'(nd), 16'h0006})
        wrap_up;
    end
endmodule // tb_cpu_mode_access_guard
